// *** rtl/pmc_pkg.sv ***
`default_nettype none
package pmc_pkg;
  // register offsets on the bus
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] OSC_OFS = 8'h08;
  // control register fields
  localparam int TRIG_BIT = 0;
  localparam int MODE_LSB = 1;
  localparam int MODE_W = 2;
  localparam int CLKSEL_BIT = 3;
  localparam int SLOWSEL_BIT = 4;
  // oscillator enable register fields
  localparam int XTAL_EN_BIT = 0;
  localparam int FAST_RC_EN_BIT = 1;
  localparam logic [1:0] OSC_RST = 2'h3;
  localparam logic CLKSEL_RST = 1'b1;
  localparam logic [1:0] MODE_RST = 2'h0;
  // sequence timing
  localparam int CLK_MHZ = 40;
  localparam int FAST_SEQ_NS = 250;
  localparam int SLOW_SEQ_NS = 2000;
  localparam int FAST_SEQ_CYC = (FAST_SEQ_NS * CLK_MHZ + 999) / 1000;
  localparam int SLOW_SEQ_CYC = (SLOW_SEQ_NS * CLK_MHZ + 999) / 1000;
  localparam int SEQ_W = 8;

  typedef enum logic [2:0] {
    PMC_RUN = 3'b000,
    PMC_GATED = 3'b001,
    PMC_DOWN = 3'b011,
    PMC_SLEEP = 3'b010,
    PMC_UP = 3'b110
  } pmc_state_e;

  function automatic logic [SEQ_W-1:0] seq_len(input logic [1:0] mode);
    seq_len = (mode == 2'h1) ? SEQ_W'(FAST_SEQ_CYC) : SEQ_W'(SLOW_SEQ_CYC);
  endfunction : seq_len
endpackage : pmc_pkg
`default_nettype wire

// *** rtl/pmc_seq_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module pmc_seq_timer #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic [W-1:0] len,
  output logic done
);
  logic [W-1:0] cnt;
  logic busy;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      busy <= 1'b0;
    end else if (start) begin
      cnt <= len;
      busy <= 1'b1;
    end else if (busy && cnt != '0) begin
      cnt <= cnt - W'(1);
    end else begin
      busy <= 1'b0;
    end
  end

  assign done = busy && cnt == '0;
endmodule : pmc_seq_timer
`default_nettype wire

// *** rtl/pmc_pin_hold.sv ***
`timescale 1ns/100ps
`default_nettype none
module pmc_pin_hold #(
  parameter int N = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic hold,
  // pins from peripherals
  input wire logic [N-1:0] core_out,
  input wire logic [N-1:0] core_oe,
  // pins to pads
  output logic [N-1:0] pad_out,
  output logic [N-1:0] pad_oe
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pad_out <= '0;
      pad_oe <= '0;
    end else if (!hold) begin
      pad_out <= core_out;
      pad_oe <= core_oe;
    end
  end
endmodule : pmc_pin_hold
`default_nettype wire

// *** rtl/pmc_top.sv ***
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - one run state plus four low-power states, zero to three
// - run state: regulator on, fast oscillator(s) on, one slow clock
// - trigger write in run with mode zero gates cpu clock and also clears sysclk_from_crystal
// - any enabled interrupt ends cpu-gated state, resuming execution
// - light sleep: fast oscillators off, regulator and slow clock stay
// - states one and two wake on reset, port or timer; three not timer
// - interrupt wake resumes; reset starts program from beginning
// - deep sleep: regulator and fast oscillators off, slow clock runs
// - deepest sleep: regulator and all oscillators off
// - pins hold direction and level during states one to three
// - power-down sequence; state one fast, three reuses state two
// - states two and three reset usb controller state
// - wake restarts the fast oscillators running at entry, plus fast rc if crystal selected
// - after wake crystal selected: run from rc until crystal stable
// - trigger set after mode field; trigger always reads zero
// - mode field cleared on entry; nonzero field blocks wake irqs
module pmc_top #(
  parameter int NPIN = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // wake sources
  input wire logic any_irq,
  input wire logic port_irq,
  input wire logic timer_irq,
  input wire logic crystal_stable_flag,
  // power and clock controls
  output logic cpu_clk_en,
  output logic regulator_on,
  output logic crystal_oscillator_on,
  output logic fast_rc_oscillator_on,
  output logic slow_rc_on,
  output logic slow_xtal_on,
  output logic sysclk_from_crystal,
  output logic usb_reset,
  output logic resume_wake,
  output logic [2:0] power_state,
  // pins
  input wire logic [NPIN-1:0] core_out,
  input wire logic [NPIN-1:0] core_oe,
  output logic [NPIN-1:0] pad_out,
  output logic [NPIN-1:0] pad_oe
);
  pmc_pkg::pmc_state_e state;
  logic [1:0] power_mode_select;
  logic [1:0] mode_taken;
  logic system_clock_source_select;
  logic slow_sel;
  logic [1:0] osc_en;
  logic [1:0] osc_saved;
  logic seq_start;
  logic seq_done;
  logic wr;
  logic trig;
  logic wake_ext;
  logic sleeping;

  assign wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && paddr != pmc_pkg::CTRL_OFS &&
      paddr != pmc_pkg::STAT_OFS && paddr != pmc_pkg::OSC_OFS;
  assign trig = wr && paddr == pmc_pkg::CTRL_OFS &&
      pwdata[pmc_pkg::TRIG_BIT];
  // wake irqs blocked while a mode is pending
  assign wake_ext = power_mode_select == 2'h0 &&
      (port_irq || (timer_irq && mode_taken != 2'h3));
  assign sleeping = state == pmc_pkg::PMC_DOWN ||
      state == pmc_pkg::PMC_SLEEP || state == pmc_pkg::PMC_UP;

  // mode field: set on write, cleared as the sleep is entered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      power_mode_select <= pmc_pkg::MODE_RST;
      system_clock_source_select <= pmc_pkg::CLKSEL_RST;
      slow_sel <= 1'b0;
      osc_en <= pmc_pkg::OSC_RST;
    end else if (state == pmc_pkg::PMC_RUN && trig &&
        power_mode_select != 2'h0) begin
      power_mode_select <= pmc_pkg::MODE_RST;
    end else if (wr && paddr == pmc_pkg::CTRL_OFS) begin
      power_mode_select <= pwdata[pmc_pkg::MODE_LSB +: pmc_pkg::MODE_W];
      system_clock_source_select <= pwdata[pmc_pkg::CLKSEL_BIT];
      slow_sel <= pwdata[pmc_pkg::SLOWSEL_BIT];
    end else if (wr && paddr == pmc_pkg::OSC_OFS) begin
      // keep at least one fast oscillator in run state
      if (pwdata[1:0] != 2'h0) begin
        osc_en <= pwdata[1:0];
      end
    end
  end

  // main sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= pmc_pkg::PMC_RUN;
      mode_taken <= 2'h0;
      osc_saved <= pmc_pkg::OSC_RST;
      resume_wake <= 1'b0;
    end else begin
      resume_wake <= 1'b0;
      case (state)
        pmc_pkg::PMC_RUN: begin
          if (trig) begin
            mode_taken <= power_mode_select;
            osc_saved <= osc_en;
            state <= (power_mode_select == 2'h0) ?
                pmc_pkg::PMC_GATED : pmc_pkg::PMC_DOWN;
          end
        end
        pmc_pkg::PMC_GATED: begin
          if (any_irq) begin
            state <= pmc_pkg::PMC_RUN;
            resume_wake <= 1'b1;
          end
        end
        pmc_pkg::PMC_DOWN: begin
          if (seq_done) begin
            state <= pmc_pkg::PMC_SLEEP;
          end
        end
        pmc_pkg::PMC_SLEEP: begin
          if (wake_ext) begin
            state <= pmc_pkg::PMC_UP;
          end
        end
        pmc_pkg::PMC_UP: begin
          if (seq_done) begin
            state <= pmc_pkg::PMC_RUN;
            resume_wake <= 1'b1;
          end
        end
        default: state <= pmc_pkg::PMC_RUN;
      endcase
    end
  end

  assign seq_start = (state == pmc_pkg::PMC_RUN && trig &&
      power_mode_select != 2'h0) ||
      (state == pmc_pkg::PMC_SLEEP && wake_ext);

  pmc_seq_timer #(
    .W(pmc_pkg::SEQ_W)
  ) u_seq (
    .clk(clk),
    .rst(rst),
    .start(seq_start),
    .len(pmc_pkg::seq_len(state == pmc_pkg::PMC_RUN ?
        power_mode_select : mode_taken)),
    .done(seq_done)
  );

  // power outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_clk_en <= 1'b1;
      regulator_on <= 1'b1;
      crystal_oscillator_on <= 1'b1;
      fast_rc_oscillator_on <= 1'b1;
      slow_rc_on <= 1'b1;
      slow_xtal_on <= 1'b0;
      usb_reset <= 1'b0;
    end else begin
      cpu_clk_en <= state == pmc_pkg::PMC_RUN;
      regulator_on <= !(state == pmc_pkg::PMC_SLEEP &&
          mode_taken != 2'h1);
      if (state == pmc_pkg::PMC_SLEEP) begin
        crystal_oscillator_on <= 1'b0;
        fast_rc_oscillator_on <= 1'b0;
      end else if (state == pmc_pkg::PMC_UP) begin
        crystal_oscillator_on <= osc_saved[pmc_pkg::XTAL_EN_BIT];
        fast_rc_oscillator_on <= osc_saved[pmc_pkg::FAST_RC_EN_BIT] ||
            !system_clock_source_select;
      end else begin
        crystal_oscillator_on <= osc_en[pmc_pkg::XTAL_EN_BIT];
        fast_rc_oscillator_on <= osc_en[pmc_pkg::FAST_RC_EN_BIT] ||
            (!system_clock_source_select && !crystal_stable_flag);
      end
      slow_rc_on <= !slow_sel &&
          !(state == pmc_pkg::PMC_SLEEP && mode_taken == 2'h3);
      slow_xtal_on <= slow_sel &&
          !(state == pmc_pkg::PMC_SLEEP && mode_taken == 2'h3);
      usb_reset <= sleeping && mode_taken[1];
    end
  end

  // crystal drives system clock only once stable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sysclk_from_crystal <= 1'b0;
    end else begin
      sysclk_from_crystal <= !system_clock_source_select &&
          crystal_stable_flag && state == pmc_pkg::PMC_RUN;
    end
  end

  pmc_pin_hold #(
    .N(NPIN)
  ) u_hold (
    .clk(clk),
    .rst(rst),
    .hold(sleeping),
    .core_out(core_out),
    .core_oe(core_oe),
    .pad_out(pad_out),
    .pad_oe(pad_oe)
  );

  assign power_state = state;

  // trigger bit reads as zero
  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
      case (paddr)
        pmc_pkg::CTRL_OFS: begin
          prdata[pmc_pkg::MODE_LSB +: pmc_pkg::MODE_W] = power_mode_select;
          prdata[pmc_pkg::CLKSEL_BIT] = system_clock_source_select;
          prdata[pmc_pkg::SLOWSEL_BIT] = slow_sel;
        end
        pmc_pkg::STAT_OFS: begin
          prdata[2:0] = state;
          prdata[3] = crystal_stable_flag;
        end
        pmc_pkg::OSC_OFS: prdata[1:0] = osc_en;
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // cycles spent powering down; too long for a repetition in a property
  logic [pmc_pkg::SEQ_W-1:0] down_cyc;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      down_cyc <= '0;
    end else if (state == pmc_pkg::PMC_DOWN) begin
      down_cyc <= down_cyc + pmc_pkg::SEQ_W'(1);
    end else begin
      down_cyc <= '0;
    end
  end

  chk_gate_wake: assert property (@(posedge clk) disable iff (rst)
      state == pmc_pkg::PMC_GATED && any_irq |=> state == pmc_pkg::PMC_RUN)
      else $error("gated state missed irq");
  chk_gate_clk: assert property (@(posedge clk) disable iff (rst)
      state == pmc_pkg::PMC_GATED |=> !cpu_clk_en)
      else $error("cpu clock not gated");
  chk_mode_clear: assert property (@(posedge clk) disable iff (rst)
      state == pmc_pkg::PMC_RUN && trig && power_mode_select != 2'h0
      |=> power_mode_select == 2'h0 && state == pmc_pkg::PMC_DOWN)
      else $error("mode not cleared on entry");
  chk_deep_timer: assert property (@(posedge clk) disable iff (rst)
      state == pmc_pkg::PMC_SLEEP && mode_taken == 2'h3 && !port_irq
      |=> state == pmc_pkg::PMC_SLEEP)
      else $error("deepest sleep woke by timer");
  chk_sleep_osc: assert property (@(posedge clk) disable iff (rst)
      state == pmc_pkg::PMC_SLEEP ##1 state == pmc_pkg::PMC_SLEEP
      |-> !crystal_oscillator_on && !fast_rc_oscillator_on)
      else $error("fast oscillator on in sleep");
  chk_regulator: assert property (@(posedge clk) disable iff (rst)
      state == pmc_pkg::PMC_SLEEP && mode_taken == 2'h1 |=> regulator_on)
      else $error("regulator off in light sleep");
  chk_pin_hold: assert property (@(posedge clk) disable iff (rst)
      sleeping && $past(sleeping) |-> $stable(pad_out) && $stable(pad_oe))
      else $error("pins moved in sleep");
  chk_fast_seq: assert property (@(posedge clk) disable iff (rst)
      state == pmc_pkg::PMC_DOWN && seq_done && mode_taken == 2'h1
      |-> int'(down_cyc) == pmc_pkg::FAST_SEQ_CYC)
      else $error("fast sequence length wrong");
  chk_slow_seq: assert property (@(posedge clk) disable iff (rst)
      state == pmc_pkg::PMC_DOWN && seq_done && mode_taken[1]
      |-> int'(down_cyc) == pmc_pkg::SLOW_SEQ_CYC)
      else $error("slow sequence length wrong");
  chk_osc_restore: assert property (@(posedge clk) disable iff (rst)
      state == pmc_pkg::PMC_UP ##1 state == pmc_pkg::PMC_UP |->
      crystal_oscillator_on == osc_saved[pmc_pkg::XTAL_EN_BIT])
      else $error("crystal restart mismatch");
  chk_usb_reset: assert property (@(posedge clk) disable iff (rst)
      state == pmc_pkg::PMC_SLEEP && mode_taken[1] |-> usb_reset)
      else $error("usb state kept in deep sleep");
  chk_trig_zero: assert property (@(posedge clk) disable iff (rst)
      psel && !pwrite && paddr == pmc_pkg::CTRL_OFS |-> !prdata[0])
      else $error("trigger bit read back as one");
  chk_deep_slow: assert property (@(posedge clk) disable iff (rst)
      state == pmc_pkg::PMC_SLEEP ##1 state == pmc_pkg::PMC_SLEEP &&
      mode_taken == 2'h3 |-> !slow_rc_on && !slow_xtal_on)
      else $error("slow clock on in deepest sleep");
endmodule : pmc_top
`default_nettype wire

// *** dv/pmc_wake_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module pmc_wake_model #(
  parameter int STABLE_CYC = 200
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // requests from the bench
  input wire logic wake_port,
  input wire logic wake_timer,
  input wire logic wake_any,
  // crystal supply
  input wire logic crystal_on,
  // wake lines and crystal status
  output logic port_irq,
  output logic timer_irq,
  output logic any_irq,
  output logic crystal_stable_flag
);
  int cnt;

  // levels held until the bench drops them, as real sources do
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_irq <= 1'b0;
      timer_irq <= 1'b0;
      any_irq <= 1'b0;
    end else begin
      port_irq <= wake_port;
      timer_irq <= wake_timer;
      any_irq <= wake_any;
    end
  end

  // flag drops whenever the crystal loses power
  always_ff @(posedge clk or posedge rst) begin
    if (rst || !crystal_on) begin
      cnt <= 0;
      crystal_stable_flag <= 1'b0;
    end else if (cnt < STABLE_CYC) begin
      cnt <= cnt + 1;
    end else begin
      crystal_stable_flag <= 1'b1;
    end
  end
endmodule : pmc_wake_model
`default_nettype wire

// *** dv/pmc_top_test.sv ***
`timescale 1ns/100ps
`default_nettype none
module pmc_top_test;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, rerr, cs;
  logic wk_port, wk_timer, wk_any, any_irq, port_irq, timer_irq, xstb;
  logic cpu_clk_en, regulator_on, xtal_on, frc_on, slow_rc, slow_xt;
  logic sysclk_xt, usb_reset, resume_wake, seen_resume;
  logic [7:0] paddr, core_out, core_oe, pad_out, pad_oe;
  logic [15:0] held;
  logic [31:0] pwdata, prdata, rdat;
  logic [2:0] power_state;
  int bad_count, checks_done, wcnt, dlen[4];
  localparam logic RW[7] = '{0, 0, 0, 0, 1, 0, 1};
  localparam logic [7:0] RA[7] = '{0, 4, 8, 12, 8, 8, 12};
  localparam logic [31:0] RD[7] = '{8, 8, 3, 0, 0, 3, 0};
  localparam logic RE[7] = '{0, 0, 0, 1, 0, 0, 1};

  pmc_top #(.NPIN(8)) dut_u (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .any_irq(any_irq), .port_irq(port_irq), .timer_irq(timer_irq),
    .crystal_stable_flag(xstb), .cpu_clk_en(cpu_clk_en),
    .regulator_on(regulator_on), .crystal_oscillator_on(xtal_on),
    .fast_rc_oscillator_on(frc_on), .slow_rc_on(slow_rc),
    .slow_xtal_on(slow_xt), .sysclk_from_crystal(sysclk_xt),
    .usb_reset(usb_reset), .resume_wake(resume_wake),
    .power_state(power_state), .core_out(core_out), .core_oe(core_oe),
    .pad_out(pad_out), .pad_oe(pad_oe));
  pmc_wake_model #(.STABLE_CYC(200)) src_u (.clk(clk), .rst(rst),
    .wake_port(wk_port), .wake_timer(wk_timer), .wake_any(wk_any),
    .crystal_on(xtal_on), .port_irq(port_irq), .timer_irq(timer_irq),
    .any_irq(any_irq), .crystal_stable_flag(xstb));

  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) if (resume_wake === 1'b1) seen_resume <= 1'b1;

  task close_out;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
    if (pready !== 1'b1) begin
      chk("pready", 1, pready);
      close_out();
    end
  endtask : apb

  task wait_on(input logic [2:0] code, input logic xs, input int lim);
    wcnt = 0;
    while (xs ? xstb !== 1'b1 : power_state !== code) begin
      @(posedge clk);
      #1 wcnt++;
      if (wcnt > lim) begin
        chk("wait", xs ? 1 : code, xs ? xstb : power_state);
        close_out();
      end
    end
  endtask : wait_on

  task enter(input logic [1:0] m, input logic [31:0] osc);
    apb(1, pmc_pkg::OSC_OFS, osc);
    if (osc[0]) wait_on(0, 1, 400);
    apb(1, pmc_pkg::CTRL_OFS, {m == 2, cs, m, 1'b0});
    apb(1, pmc_pkg::CTRL_OFS, {m == 2, cs, m, 1'b1});
    wait_on(pmc_pkg::PMC_SLEEP, 0, 400);
    dlen[m] = wcnt;
  endtask : enter

  task sleep_run(input logic [1:0] m, input logic [31:0] osc);
    enter(m, osc);
    // power outputs are registered from the state, one edge behind it
    @(posedge clk);
    #1 chk("fast_osc", 0, {xtal_on, frc_on, cpu_clk_en});
    chk("regulator", m == 1, regulator_on);
    chk("slow_clk", m == 3 ? 0 : (m == 2 ? 2 : 1), {slow_xt, slow_rc});
    chk("usb_reset", m != 1, usb_reset);
    held = {pad_oe, pad_out};
    @(posedge clk);
    core_out <= ~core_out;
    core_oe <= ~core_oe;
    repeat (3) @(posedge clk);
    #1 chk("pad_hold", held, {pad_oe, pad_out});
    @(posedge clk);
    // cleared before the timer, which may already wake states one and two
    seen_resume <= 0;
    wk_timer <= 1;
    repeat (20) @(posedge clk);
    #1 if (m == 3) chk("no_timer_wake", 2, power_state);
    @(posedge clk);
    wk_port <= m == 3;
    wait_on(pmc_pkg::PMC_RUN, 0, 400);
    @(posedge clk);
    #1 chk("resume", 1, seen_resume);
    chk("fast_back", osc[1:0], {frc_on, xtal_on});
    if (!cs) chk("rc_until_stable", 2'h1, {sysclk_xt, frc_on});
    if (!cs) wait_on(0, 1, 400);
    repeat (3) @(posedge clk);
    #1 if (!cs) chk("sysclk_crystal", 1, sysclk_xt);
    wk_timer <= 0;
    wk_port <= 0;
    apb(0, pmc_pkg::CTRL_OFS, 0);
    chk("mode_clear", 0, rdat[2:0]);
  endtask : sleep_run

  initial begin
    rst = 1;
    {psel, penable, pwrite, paddr, pwdata, wk_port, wk_timer, wk_any} = 0;
    {core_out, core_oe, cs, bad_count, checks_done, seen_resume} = 0;
    core_out = 8'h5a;
    core_oe = 8'h0f;
    repeat (20) @(posedge clk);
    rst <= 0;
    #1 chk("run_out", 6'h3e, {cpu_clk_en, regulator_on, xtal_on,
      frc_on, slow_rc, slow_xt});
    chk("state", 0, power_state);
    wait_on(0, 1, 400);
    for (int i = 0; i < 7; i++) begin
      apb(RW[i], RA[i], 0);
      if (!RW[i]) chk("rdata", RD[i], rdat);
      chk("slverr", RE[i], rerr);
    end
    cs = 1;
    apb(1, pmc_pkg::CTRL_OFS, 32'h0000_0009);
    @(posedge clk);
    #1 chk("gated", 32'h0000_0017, {power_state, cpu_clk_en,
      regulator_on, xtal_on, frc_on});
    @(posedge clk);
    wk_any <= 1;
    wait_on(pmc_pkg::PMC_RUN, 0, 4);
    @(posedge clk);
    wk_any <= 0;
    sleep_run(1, 32'h0000_0002);
    sleep_run(3, 32'h0000_0003);
    cs = 0;
    sleep_run(2, 32'h0000_0003);
    chk("seq_fast", 1, dlen[1] < dlen[2]);
    chk("seq_same", dlen[2], dlen[3]);
    enter(2, 32'h0000_0003);
    @(posedge clk);
    seen_resume <= 0;
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    #1 chk("reset_wake", 6'h03, {seen_resume, power_state,
      regulator_on, cpu_clk_en});
    close_out();
  end
endmodule : pmc_top_test
`default_nettype wire
